// [design/alcg_pkg.sv]
// Shared constants and types of the automatic level controller
package alcg_pkg;

   // -------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------
   localparam int ADC_W = 24;
   localparam int MAG_W = 23;
   localparam int GAIN_W = 6;
   localparam int ATT_W = 8;
   localparam int REG_W = 9;
   localparam int IDX_W = 10;

   // -------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [9:0] IDX_LIMITS = 10'h020;
   localparam logic [9:0] IDX_HOLD_TARGET = 10'h021;
   localparam logic [9:0] IDX_MODE_TIMING = 10'h022;
   localparam logic [9:0] IDX_GATE = 10'h023;
   localparam logic [9:0] IDX_GAIN_LEFT = 10'h046;
   localparam logic [9:0] IDX_GAIN_RIGHT = 10'h047;
   localparam logic [9:0] IDX_LEVEL_P2P = 10'h04c;
   localparam logic [9:0] IDX_LEVEL_PEAK = 10'h04d;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int FLOOR_LSB = 0;
   localparam int CEIL_LSB = 3;
   localparam int CHEN_LSB = 7;
   localparam int TARGET_LSB = 0;
   localparam int HOLD_LSB = 4;
   localparam int ATTACK_LSB = 0;
   localparam int DECAY_LSB = 4;
   localparam int LIMITER_BIT = 8;
   localparam int THRESH_LSB = 0;
   localparam int GATE_EN_BIT = 3;
   localparam int TABLE_SEL_BIT = 7;
   localparam int AVG_SEL_BIT = 8;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [2:0] FLOOR_RST = 3'h0;
   localparam logic [2:0] CEIL_RST = 3'h7;
   localparam logic [1:0] CHEN_RST = 2'h0;
   localparam logic [3:0] TARGET_RST = 4'hb;
   localparam logic [3:0] HOLD_RST = 4'h0;
   localparam logic [3:0] ATTACK_RST = 4'h2;
   localparam logic [3:0] DECAY_RST = 4'h3;
   localparam logic LIMITER_RST = 1'b0;
   localparam logic [2:0] THRESH_RST = 3'h0;
   localparam logic GATE_EN_RST = 1'b0;

   // -------------------------------------------------------------
   // Gain and level scales in 0.75 dB units, clip magnitude and shift amounts
   // -------------------------------------------------------------
   localparam logic [5:0] GAIN_RST = 6'h10;
   localparam logic [2:0] CEIL_FINE = 3'h7;
   localparam logic [9:0] GAIN_ZERO_DB = 10'h010;
   localparam logic [9:0] BOOST_UNITS = 10'h01b;
   localparam logic [3:0] TARGET_TOP = 4'hf;
   localparam logic [7:0] TARGET_MIN_ATT = 8'h02;
   localparam logic [7:0] MARGIN_ATT = 8'h02;
   localparam logic [9:0] GATE_BASE_ATT = 10'h060;
   localparam int GATE_STEP_SHIFT = 3;
   localparam logic [22:0] CLIP_MAG = 23'h700000;
   localparam int PEAK_DECAY_SHIFT = 8;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned ATTACK_BASE_NS = 125000;
   localparam int unsigned DECAY_BASE_NS = 500000;
   localparam int unsigned HOLD_BASE_NS = 2000000;
   localparam int unsigned ATTACK_BASE_CYC = ATTACK_BASE_NS / CLK_PERIOD_NS;
   localparam int unsigned DECAY_BASE_CYC = DECAY_BASE_NS / CLK_PERIOD_NS;
   localparam int unsigned HOLD_BASE_CYC = HOLD_BASE_NS / CLK_PERIOD_NS;
   localparam logic [3:0] TIME_CODE_MAX = 4'ha;
   localparam int LIMIT_SPEED_SHIFT = 2;

   // -------------------------------------------------------------
   // Controller states and state record
   // -------------------------------------------------------------
   typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_ATTACK, ST_HOLD, ST_DECAY} alcg_state_e;

   typedef struct packed {
      logic [1:0] chEn;
      logic [2:0] gainFloor;
      logic [2:0] gainCeil;
      logic [3:0] target;
      logic [3:0] hold;
      logic [3:0] attack;
      logic [3:0] decay;
      logic limiter;
      logic gateEn;
      logic [2:0] gateTh;
      logic avgSel;
      logic tableSel;
      logic [1:0][5:0] gain;
      logic [1:0][5:0] limCeil;
      logic limPrev;
      alcg_state_e st;
      logic [31:0] stepCnt;
      logic [31:0] holdCnt;
      logic gateOn;
      logic [8:0] prdata;
      logic pready;
      logic pslverr;
   } alcg_top_s;

endpackage

// [design/alcg_level_det.sv]
// Per-channel signal level detector: decaying peak and peak-to-peak
`timescale 1ns/1ps
module alcg_level_det
   import alcg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic [ADC_W-1:0] sampleIn,
   input wire logic sampleValid,
   output logic [ATT_W-1:0] peakAtt,
   output logic [ATT_W-1:0] p2pAtt,
   output logic clip
);

   typedef struct packed {
      logic [MAG_W-1:0] peak;
      logic signed [ADC_W-1:0] hi;
      logic signed [ADC_W-1:0] lo;
      logic [ATT_W-1:0] peakAtt;
      logic [ATT_W-1:0] p2pAtt;
      logic clip;
   } alcg_det_s;

   alcg_det_s r;
   alcg_det_s n;
   logic [ADC_W-1:0] absVal;
   logic [MAG_W-1:0] mag;
   logic signed [ADC_W:0] span;
   logic [MAG_W-1:0] halfSpan;

   // Magnitude to attenuation below full scale, 0.75 dB units, log2 with 3-bit mantissa
   function automatic logic [ATT_W-1:0] magToAtt(input logic [MAG_W-1:0] m);
      logic [MAG_W-1:0] norm;
      logic [ATT_W-1:0] att;
      norm = m;
      att = 8'hff;
      for (int p = 0; p < MAG_W; p++) begin
         if (m[p]) begin
            norm = m << (MAG_W - 1 - p);
            att = 8'((MAG_W - 1 - p) * 8) + {5'h0, ~norm[MAG_W-2 -: 3]};
         end
      end
      return att;
   endfunction

   // Saturating magnitude; the most negative code would not fit otherwise
   always_comb begin
      absVal = sampleIn[ADC_W-1] ? (~sampleIn + 24'h1) : sampleIn;
      mag = absVal[ADC_W-1] ? 23'h7fffff : absVal[MAG_W-1:0];
      span = 25'(r.hi) - 25'(r.lo);
      halfSpan = span[ADC_W] ? 23'h7fffff : span[MAG_W:1];
   end

   // Envelope tracking; decay per sample keeps the envelope following quiet passages
   always_comb begin
      n = r;
      if (sampleValid) begin
         n.peak = (mag > r.peak) ? mag : r.peak - (r.peak >> PEAK_DECAY_SHIFT);
         n.hi = ($signed(sampleIn) > r.hi) ? $signed(sampleIn) : r.hi - (r.hi >>> PEAK_DECAY_SHIFT);
         n.lo = ($signed(sampleIn) < r.lo) ? $signed(sampleIn) : r.lo - (r.lo >>> PEAK_DECAY_SHIFT);
         n.clip = mag >= CLIP_MAG;
      end
      n.peakAtt = magToAtt(r.peak);
      n.p2pAtt = magToAtt(halfSpan);
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= '0;
      end else if (clkEn) begin
         r <= n;
      end
   end

   assign peakAtt = r.peakAtt;
   assign p2pAtt = r.p2pAtt;
   assign clip = r.clip;

endmodule // alcg_level_det

// [design/alcg_top.sv]
// Automatic level controller for the stereo microphone preamp, APB slave
//
// Operation
// R1 - Gate enable bit, three-bit gate threshold
// R2 - Gate asserted: never raise preamp gain
// R3 - Gate active only in enabled normal mode
// R4 - Gate on input-referred level below threshold
// R5 - Per-channel enable, all other settings shared
// R6 - Disabled preamp keeps last assigned gain
// R7 - Channel enable decode, resets to 00
// R8 - Gain floor -12 to +30 dB, all modes
// R9 - Gain ceiling -6.75 to +35.25 dB, normal
// R10 - Target -22.5 to -1.5 dBFS, reset -6
// R11 - Hold time doubles per code, max 1024 ms
// R12 - Attack time doubles per code, limiter faster
// R13 - Decay time doubles per code, limiter faster
// R14 - Mode bit selects limiter when enabled
// R15 - Limiter caps gain at entry value
// R16 - Readback of left and right gain
// R17 - Readback of peak and peak-to-peak levels
// R18 - Averaging and gain table option bits
// R19 - Above target: step down until 1.5 dB below
// R20 - 1.5 dB below target: step up at decay
// R21 - Raise only after full hold time below target
// R22 - Near clipping: fastest attack in any mode
// R23 - Readback values are read-only
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module alcg_top
   import alcg_pkg::*;
#(
   parameter int unsigned ATTACK_BASE_P = ATTACK_BASE_CYC,
   parameter int unsigned DECAY_BASE_P = DECAY_BASE_CYC,
   parameter int unsigned HOLD_BASE_P = HOLD_BASE_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ADC_W-1:0] adcRight,
   input wire logic [ADC_W-1:0] adcLeft,
   input wire logic adcValid,
   input wire logic boostRight,
   input wire logic boostLeft,
   input wire logic pgaEnRight,
   input wire logic pgaEnLeft,
   output logic [GAIN_W-1:0] pgaGainRight,
   output logic [GAIN_W-1:0] pgaGainLeft,
   output logic gateOn
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   alcg_top_s r;
   alcg_top_s n;
   logic [1:0][ADC_W-1:0] adcIn;
   logic [1:0] boost;
   logic [1:0] pgaEn;
   logic [1:0][ATT_W-1:0] peakAtt;
   logic [1:0][ATT_W-1:0] p2pAtt;
   logic [1:0] clip;
   logic [IDX_W-1:0] idx;
   logic wrEn;
   logic hit;
   logic [REG_W-1:0] rdVal;
   logic active;
   logic limMode;
   logic emerg;
   logic [1:0] mask;
   logic [ATT_W-1:0] level;
   logic [ATT_W-1:0] lvlP2p;
   logic [ATT_W-1:0] lvlPeak;
   logic [ATT_W-1:0] targetAtt;
   logic above;
   logic quiet;
   logic gateEff;
   logic [1:0] chGated;
   logic [9:0] gateAtt;
   logic [31:0] atkInt;
   logic [31:0] dcyInt;
   logic [31:0] holdInt;
   logic holdDone;
   logic stepFire;
   logic [6:0] stepSz;
   alcg_state_e stNxt;

   assign adcIn = {adcLeft, adcRight};
   assign boost = {boostLeft, boostRight};
   assign pgaEn = {pgaEnLeft, pgaEnRight};
   assign idx = paddr[11:2];

   // Clamp a time code; codes past the top give the longest time
   function automatic logic [3:0] timeCode(input logic [3:0] c);
      return (c > TIME_CODE_MAX) ? TIME_CODE_MAX : c;
   endfunction

   // ----------------------------------------------------------------
   // Level detectors, one per channel
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : gDet
      alcg_level_det uDet (
         .clk_sys(clk_sys),
         .nrst(nrst),
         .clkEn(clkEn),
         .sampleIn(adcIn[ch]),
         .sampleValid(adcValid),
         .peakAtt(peakAtt[ch]),
         .p2pAtt(p2pAtt[ch]),
         .clip(clip[ch])
      );
   end

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   always_comb begin
      rdVal = '0;
      hit = 1'b1;
      case (idx)
         IDX_LIMITS: begin
            rdVal[FLOOR_LSB +: 3] = r.gainFloor;
            rdVal[CEIL_LSB +: 3] = r.gainCeil;
            rdVal[CHEN_LSB +: 2] = r.chEn;
         end
         IDX_HOLD_TARGET: begin
            rdVal[TARGET_LSB +: 4] = r.target;
            rdVal[HOLD_LSB +: 4] = r.hold;
         end
         IDX_MODE_TIMING: begin
            rdVal[ATTACK_LSB +: 4] = r.attack;
            rdVal[DECAY_LSB +: 4] = r.decay;
            rdVal[LIMITER_BIT] = r.limiter;
         end
         IDX_GATE: begin
            rdVal[THRESH_LSB +: 3] = r.gateTh;
            rdVal[GATE_EN_BIT] = r.gateEn;
         end
         IDX_GAIN_LEFT: begin
            rdVal[GAIN_W-1:0] = r.gain[1]; // R16
            rdVal[TABLE_SEL_BIT] = r.tableSel;
            rdVal[AVG_SEL_BIT] = r.avgSel;
         end
         IDX_GAIN_RIGHT: rdVal[GAIN_W-1:0] = r.gain[0]; // R16
         IDX_LEVEL_P2P: rdVal[ATT_W-1:0] = lvlP2p; // R17
         IDX_LEVEL_PEAK: rdVal[ATT_W-1:0] = lvlPeak; // R17
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Level decision and timing
   // ----------------------------------------------------------------
   // Decisions follow the louder of the enabled channels
   always_comb begin
      active = |r.chEn; // R7
      limMode = r.limiter && active; // R14
      mask = active ? r.chEn : 2'h3;
      lvlP2p = 8'hff;
      lvlPeak = 8'hff;
      for (int ch = 0; ch < 2; ch++) begin
         if (mask[ch] && p2pAtt[ch] < lvlP2p) lvlP2p = p2pAtt[ch];
         if (mask[ch] && peakAtt[ch] < lvlPeak) lvlPeak = peakAtt[ch];
      end
      level = r.avgSel ? lvlP2p : lvlPeak; // R18
      emerg = active && |(clip & r.chEn); // R22
      targetAtt = (r.target == TARGET_TOP) ? TARGET_MIN_ATT : 8'((TARGET_TOP - r.target) * 2); // R10
      if (targetAtt < TARGET_MIN_ATT) targetAtt = TARGET_MIN_ATT;
      above = level < targetAtt;
      quiet = {1'b0, level} >= {1'b0, targetAtt} + {1'b0, MARGIN_ATT};
   end

   // Gate compares the input-referred level, so preamp and boost gain come off
   always_comb begin
      gateAtt = GATE_BASE_ATT - ({7'h0, r.gateTh} << GATE_STEP_SHIFT); // R1
      for (int ch = 0; ch < 2; ch++) begin
         chGated[ch] = ({2'h0, peakAtt[ch]} + {4'h0, r.gain[ch]} + (boost[ch] ? BOOST_UNITS : 10'h0))
                       > (gateAtt + GAIN_ZERO_DB); // R4
      end
      gateEff = active && !limMode && r.gateEn && ((chGated & r.chEn) == r.chEn); // R3
   end

   // Step intervals; limiter runs four times faster, emergency at the fastest
   always_comb begin
      atkInt = ATTACK_BASE_P << timeCode(r.attack); // R12
      dcyInt = DECAY_BASE_P << timeCode(r.decay); // R13
      if (limMode) begin
         atkInt = atkInt >> LIMIT_SPEED_SHIFT;
         dcyInt = dcyInt >> LIMIT_SPEED_SHIFT;
      end
      if (emerg) atkInt = ATTACK_BASE_P >> LIMIT_SPEED_SHIFT; // R22
      holdInt = (r.hold == 4'h0) ? 32'h0 : HOLD_BASE_P << (timeCode(r.hold) - 4'h1); // R11
      holdDone = r.holdCnt >= holdInt; // R21
   end

   // State choice; attack keeps going until 1.5 dB below target
   always_comb begin
      if (!active) begin
         stNxt = ST_OFF;
      end else if (emerg || above || (r.st == ST_ATTACK && !quiet)) begin
         stNxt = ST_ATTACK; // R19
      end else if (quiet && gateEff) begin
         stNxt = ST_WAIT; // R2
      end else if (quiet && holdDone) begin
         stNxt = ST_DECAY; // R20
      end else if (quiet) begin
         stNxt = ST_HOLD; // R21
      end else begin
         stNxt = ST_WAIT;
      end
   end

   assign stepFire = (r.st == ST_ATTACK) ? (r.stepCnt + 32'h1 >= atkInt)
                   : (r.st == ST_DECAY) ? (r.stepCnt + 32'h1 >= dcyInt) : 1'b0;
   assign stepSz = r.tableSel ? 7'h2 : 7'h1; // R18
   assign wrEn = psel && penable && pwrite && r.pready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [6:0] g;
      logic [6:0] lo;
      logic [6:0] hi;
      g = 7'h00;
      lo = 7'h00;
      hi = 7'h00;
      n = r;
      // APB: one wait state, answer registered
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && penable && !r.pready) begin
         n.pready = 1'b1;
         n.prdata = rdVal;
         n.pslverr = !hit;
      end
      // Writes; readback fields are never written
      if (wrEn) begin
         case (idx)
            IDX_LIMITS: begin
               n.gainFloor = pwdata[FLOOR_LSB +: 3]; // R8
               n.gainCeil = pwdata[CEIL_LSB +: 3]; // R9
               n.chEn = pwdata[CHEN_LSB +: 2]; // R5
            end
            IDX_HOLD_TARGET: begin
               n.target = pwdata[TARGET_LSB +: 4];
               n.hold = pwdata[HOLD_LSB +: 4];
            end
            IDX_MODE_TIMING: begin
               n.attack = pwdata[ATTACK_LSB +: 4];
               n.decay = pwdata[DECAY_LSB +: 4];
               n.limiter = pwdata[LIMITER_BIT]; // R14
            end
            IDX_GATE: begin
               n.gateTh = pwdata[THRESH_LSB +: 3]; // R1
               n.gateEn = pwdata[GATE_EN_BIT]; // R1
            end
            IDX_GAIN_LEFT: begin
               n.tableSel = pwdata[TABLE_SEL_BIT]; // R18
               n.avgSel = pwdata[AVG_SEL_BIT];
            end
            default: n.st = r.st;
         endcase
      end
      // Step timer restarts whenever the state changes or a step fires
      n.st = stNxt;
      n.stepCnt = (stNxt != r.st || stepFire) ? 32'h0 : r.stepCnt + 32'h1;
      n.holdCnt = (!active || above) ? 32'h0 : (holdDone ? r.holdCnt : r.holdCnt + 32'h1); // R21
      n.gateOn = gateEff;
      // Limiter entry freezes the current gain as the cap
      n.limPrev = limMode;
      if (limMode && !r.limPrev) n.limCeil = r.gain; // R15
      // Gain steps; a disabled channel or preamp holds its gain
      for (int ch = 0; ch < 2; ch++) begin
         g = {1'b0, r.gain[ch]};
         lo = {1'b0, r.gainFloor, 3'h0}; // R8
         hi = limMode ? {1'b0, (r.limPrev ? r.limCeil[ch] : r.gain[ch])} // R15
                      : {1'b0, r.gainCeil, CEIL_FINE}; // R9
         if (stepFire && r.chEn[ch] && pgaEn[ch]) begin // R6
            if (r.st == ST_ATTACK && g > lo) begin
               g = (g > lo + stepSz) ? g - stepSz : lo; // R19
            end else if (r.st == ST_DECAY && !gateEff && g < hi) begin
               g = (g + stepSz < hi) ? g + stepSz : hi; // R20
            end
         end
         n.gain[ch] = g[GAIN_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r <= '0;
         r.chEn <= CHEN_RST; // R7
         r.gainFloor <= FLOOR_RST;
         r.gainCeil <= CEIL_RST;
         r.target <= TARGET_RST;
         r.hold <= HOLD_RST;
         r.attack <= ATTACK_RST;
         r.decay <= DECAY_RST;
         r.limiter <= LIMITER_RST;
         r.gateTh <= THRESH_RST;
         r.gateEn <= GATE_EN_RST;
         r.gain <= {GAIN_RST, GAIN_RST};
         r.limCeil <= {GAIN_RST, GAIN_RST};
         r.st <= ST_OFF;
      end else if (clkEn) begin
         r <= n;
      end
   end

   assign prdata = {23'h0, r.prdata};
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign pgaGainRight = r.gain[0];
   assign pgaGainLeft = r.gain[1];
   assign gateOn = r.gateOn;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence apbSetup;
      psel && penable && !r.pready && clkEn;
   endsequence
   sequence gainRiseL;
      r.gain[1] > $past(r.gain[1]);
   endsequence
   sequence gainFallL;
      r.gain[1] < $past(r.gain[1]);
   endsequence

   apb_answer_a: assert property (apbSetup |=> r.pready && r.prdata == $past(rdVal)) // R16
      else $error("APB answer missing or wrong data");
   reset_vals_a: assert property ($past(!nrst) |-> r.chEn == CHEN_RST && r.gainCeil == CEIL_RST // R7
      && r.target == TARGET_RST && r.attack == ATTACK_RST && r.decay == DECAY_RST)
      else $error("Register reset value wrong");
   gate_hold_a: assert property (r.gateOn |-> !(r.gain[1] > $past(r.gain[1]))) // R2
      else $error("Gain rose while gate asserted");
   gate_mode_a: assert property (r.gateOn |-> !$past(r.limiter) && $past(r.chEn) != 2'h0) // R3
      else $error("Gate asserted outside normal mode");
   chan_hold_a: assert property ($past(clkEn) && !$past(r.chEn[1] && pgaEnLeft) |-> $stable(r.gain[1])) // R6
      else $error("Gain changed on disabled channel");
   floor_a: assert property (gainFallL |-> r.gain[1] >= {$past(r.gainFloor), 3'h0}) // R8
      else $error("Gain stepped below floor");
   ceil_a: assert property (gainRiseL and !$past(r.limiter) |-> r.gain[1] <= {$past(r.gainCeil), CEIL_FINE}) // R9
      else $error("Gain stepped above ceiling");
   limit_cap_a: assert property (gainRiseL and $past(limMode && r.limPrev) |-> r.gain[1] <= $past(r.limCeil[1])) // R15
      else $error("Limiter cap exceeded");
   hold_wait_a: assert property (gainRiseL |-> $past(holdDone) && $past(r.st) == ST_DECAY) // R21
      else $error("Gain raised before hold time");
   emerg_atk_a: assert property (clkEn && emerg |=> r.st == ST_ATTACK) // R22
      else $error("Clipping did not force attack");
   attack_dir_a: assert property ($past(r.st) == ST_ATTACK |-> !(r.gain[1] > $past(r.gain[1]))) // R19
      else $error("Gain rose during attack");

endmodule // alcg_top

// [dv/alcg_adc_model.sv]
// ADC decimator stand-in: square wave of set amplitude, one sample pair every four cycles
`timescale 1ns/1ps
module alcg_adc_model
   import alcg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [ADC_W-1:0] amp,
   output logic [ADC_W-1:0] adcLeft,
   output logic [ADC_W-1:0] adcRight,
   output logic adcValid
);
   logic [1:0] phase_r;
   // Sign flips every sample so the peak detectors see a full swing
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         phase_r <= 2'h0;
         adcValid <= 1'b0;
         adcLeft <= '0;
         adcRight <= '0;
      end else begin
         phase_r <= phase_r + 2'h1;
         adcValid <= (phase_r == 2'h3);
         if (phase_r == 2'h3) begin
            adcLeft <= adcLeft[ADC_W-1] ? amp : -amp;
            adcRight <= adcLeft[ADC_W-1] ? -amp : amp;
         end
      end
   end
endmodule // alcg_adc_model

// [dv/testbench.sv]
// Self-checking bench of the level controller: registers, gain steering, gate, limiter
`timescale 1ns/1ps
module testbench;
   import alcg_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd, dat;
   logic pready, pslverr, gateOn, adcValid, err;
   logic [ADC_W-1:0] amp = '0;
   logic [ADC_W-1:0] adcLeft, adcRight;
   logic boostLeft = 1'b0, boostRight = 1'b0, pgaEnLeft = 1'b1, pgaEnRight = 1'b1;
   logic [GAIN_W-1:0] pgaGainLeft, pgaGainRight, held;
   int failures = 0, check_count = 0, seed = 55458;
   // -------------------------------------------------------------
   // Clock, design and far side
   // -------------------------------------------------------------
   always #2.5 clk_sys = ~clk_sys;
   // Short step timers keep the run to some twenty thousand cycles
   alcg_top #(.ATTACK_BASE_P(8), .DECAY_BASE_P(32), .HOLD_BASE_P(16)) alcg_top_inst (
      .clk_sys, .nrst, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .adcRight, .adcLeft, .adcValid, .boostRight, .boostLeft,
      .pgaEnRight, .pgaEnLeft, .pgaGainRight, .pgaGainLeft, .gateOn);
   alcg_adc_model alcg_adc_model_inst (.clk_sys, .nrst, .amp, .adcLeft, .adcRight, .adcValid);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) begin
         failures++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   initial begin
      logic [9:0] idxs [8] = '{IDX_LIMITS, IDX_HOLD_TARGET, IDX_MODE_TIMING, IDX_GATE,
                              IDX_GAIN_LEFT, IDX_GAIN_RIGHT, IDX_LEVEL_P2P, IDX_LEVEL_PEAK};
      logic [31:0] rstv [8] = '{32'h38, 32'hb, 32'h32, 32'h0, 32'h10, 32'h10, 32'hff, 32'hff};
      logic [31:0] msk [4] = '{32'h1bf, 32'hff, 32'h1ff, 32'hf};
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      // Silent input reads as the largest attenuation code on both level readbacks
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, idxs[i], '0);
         chk("reset value", rstv[i], rd);
      end
      // Random contents, then defaults restored so later timing is known
      for (int i = 0; i < 4; i++) begin
         dat = $random(seed) & msk[i];
         apb(1'b1, idxs[i], dat);
         apb(1'b0, idxs[i], '0);
         chk("written value", dat, rd);
         apb(1'b1, idxs[i], rstv[i]);
      end
      apb(1'b1, IDX_GAIN_RIGHT, 32'h3f);
      apb(1'b0, IDX_GAIN_RIGHT, '0);
      chk("gain readback", 32'h10, rd);
      apb(1'b1, IDX_GAIN_LEFT, 32'h1bf);
      apb(1'b0, IDX_GAIN_LEFT, '0);
      chk("option bits", 32'h190, rd);
      apb(1'b1, IDX_GAIN_LEFT, '0);
      apb(1'b0, 10'h030, '0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test registers done");
      // Clipping input drives both channels down to a floor of -6 dB
      amp <= 24'h7fffff;
      boostLeft <= 1'($random(seed));
      apb(1'b1, IDX_LIMITS, 32'h1b9);
      repeat (3000) @(posedge clk_sys);
      chk("left floor", 32'h8, pgaGainLeft);
      chk("right floor", 32'h8, pgaGainRight);
      apb(1'b0, IDX_LEVEL_PEAK, '0);
      chk("peak level", 32'h0, rd);
      amp <= 24'h000100;
      pgaEnLeft <= 1'b0;
      repeat (4000) @(posedge clk_sys);
      chk("frozen left", 32'h8, pgaGainLeft);
      chk("right rises", 32'h1, {31'h0, pgaGainRight > 6'h8});
      $display("test attack and decay done");
      pgaEnLeft <= 1'b1;
      apb(1'b1, IDX_GATE, 32'hf);
      // Long enough for the decaying envelope to gate both channels
      repeat (1000) @(posedge clk_sys);
      held = pgaGainRight;
      repeat (3000) @(posedge clk_sys);
      chk("gated gain", held, pgaGainRight);
      chk("gate flag", 32'h1, gateOn);
      apb(1'b1, IDX_MODE_TIMING, 32'h132);
      repeat (3000) @(posedge clk_sys);
      chk("limiter cap", 32'h1, {31'h0, pgaGainRight <= held});
      chk("gate in limiter", 32'h0, gateOn);
      // Ceiling code 2 is +5.25 dB, gain code 0x17
      apb(1'b1, IDX_GATE, '0);
      apb(1'b1, IDX_MODE_TIMING, 32'h32);
      apb(1'b1, IDX_GAIN_LEFT, 32'h180);
      apb(1'b1, IDX_LIMITS, 32'h191);
      repeat (8000) @(posedge clk_sys);
      chk("left ceiling", 32'h17, pgaGainLeft);
      chk("right ceiling", 32'h17, pgaGainRight);
      $display("test gate and limiter done");
      complete_run();
   end
endmodule // testbench
